// ### design/bay_ctl_regs.sv
// two-bay control/status register bank with bay state logic
`default_nettype none
module bay_ctl_regs
	import bay_regs_pkg::*;
#(
	parameter int unsigned TICK_CYCLES = SOL_TICK_CYC
) (
	// clock and resets
	input wire logic i_core_clk,
	input wire logic i_rst_n,
	input wire logic i_por_n,
	// byte register port
	input wire logic [7:0] i_reg_addr,
	input wire logic i_reg_wr,
	input wire logic [7:0] i_reg_wdata,
	input wire logic i_reg_rd,
	output logic [7:0] o_reg_rdata,
	// configuration from special function and capability registers
	input wire logic [3:0] i_solenoid_length_field,
	input wire logic i_pulse_length_select,
	input wire logic i_security_lock_present,
	// bay pins, active low
	input wire logic [1:0] i_serial_bus_presence_in_n,
	input wire logic [1:0] i_usb_presence_in_n,
	input wire logic [1:0] i_remove_request_in_n,
	input wire logic [1:0] i_security_lock_in_n,
	// bay outputs
	output logic [1:0] o_solenoid_drive_out,
	output logic [1:0] o_rail_gate_drive_out,
	output logic o_alert_out
);
	import bay_regs_pkg::*;

	typedef struct packed {
		logic [7:0] syn1;
		logic [7:0] syn2;
		logic [1:0] prs_d;
		logic [1:0] rr_d;
		logic [1:0] lock;
		logic [1:0][2:0] req;
		logic [1:0] rr_en;
		logic [1:0] sc_en;
		logic [1:0] wk_en;
		logic [1:0] pwr;
		logic [1:0] rr_flag;
		logic [1:0] sc_flag;
		logic [1:0][2:0] bst;
		logic [1:0] sol;
		logic [7:0] rdata;
		logic [31:0] tick_cnt;
		logic tick;
	} ctl_t;

	// pins idle high, so synchronisers and remove-request history reset to 1, presence history to 0
	localparam ctl_t CTL_INIT = '{syn1: 8'hff, syn2: 8'hff, prs_d: 2'h0, rr_d: 2'h3,
		lock: 2'h0, req: 6'h00, rr_en: 2'h0, sc_en: 2'h0, wk_en: 2'h0, pwr: 2'h0,
		rr_flag: 2'h0, sc_flag: 2'h0, bst: 6'h00, sol: 2'h0, rdata: 8'h00,
		tick_cnt: 32'h0, tick: 1'b0};

	ctl_t st_r;
	ctl_t st_nxt;
	logic [1:0][2:0] ff_r;
	logic [1:0] ff_done_r;
	logic [1:0] pls_start;
	logic [1:0] pls_act;
	logic [1:0] present;
	logic [1:0] insert_ev;
	logic [1:0] remove_ev;
	logic [1:0] rr_ev;
	logic [1:0] ctl_wr;
	logic [1:0] sts_wr;
	logic [1:0] ff_wr;
	logic level_mode;

	// byte address to bay-register word, built on word index
	function automatic logic hit(input logic [7:0] a, input logic [7:0] base);
		return a[7:2] == base[7:2];
	endfunction

	function automatic logic [31:0] ctl_word(input ctl_t s, input int b);
		logic [31:0] w;
		w = CTL_RESET;
		w[CTL_LOCK_BIT] = s.lock[b];
		w[CTL_REQ_LSB +: 3] = s.req[b];
		w[CTL_RR_EN_BIT] = s.rr_en[b];
		w[CTL_SC_EN_BIT] = s.sc_en[b];
		w[CTL_WAKE_EN_BIT] = s.wk_en[b];
		w[CTL_PWR_BIT] = s.pwr[b];
		return w;
	endfunction

	// syn2 layout: [7:6] secure, [5:4] remove req, [3:2] usb, [1:0] serial
	function automatic logic [31:0] sts_word(input ctl_t s, input logic [2:0] ff,
		input logic sec_cap, input int b);
		logic [31:0] w;
		w = STS_RESET;
		w[STS_FF_LSB +: 3] = ff;
		w[STS_SEC_BIT] = sec_cap & ~s.syn2[6 + b];
		w[STS_ST_LSB +: 3] = s.bst[b];
		w[STS_RR_BIT] = s.rr_flag[b];
		w[STS_SC_BIT] = s.sc_flag[b];
		w[STS_SER_BIT] = ~s.syn2[b];
		w[STS_USB_BIT] = ~s.syn2[2 + b];
		return w;
	endfunction

	assign level_mode = (i_solenoid_length_field == 4'h0);

	// pin-derived events and register strobes per bay
	always_comb begin
		for (int b = 0; b < 2; b++) begin
			present[b] = ~st_r.syn2[b] | ~st_r.syn2[2 + b];
			insert_ev[b] = present[b] & ~st_r.prs_d[b];
			remove_ev[b] = ~present[b] & st_r.prs_d[b];
		end
		// status byte 1 carries the write-once form factor
		ctl_wr[0] = i_reg_wr && hit(i_reg_addr, ADDR_BAY0_CTL) && i_reg_addr[1:0] == 2'h0;
		ctl_wr[1] = i_reg_wr && hit(i_reg_addr, ADDR_BAY1_CTL) && i_reg_addr[1:0] == 2'h0;
		sts_wr[0] = i_reg_wr && hit(i_reg_addr, ADDR_BAY0_STS) && i_reg_addr[1:0] == 2'h0;
		sts_wr[1] = i_reg_wr && hit(i_reg_addr, ADDR_BAY1_STS) && i_reg_addr[1:0] == 2'h0;
		ff_wr[0] = i_reg_wr && hit(i_reg_addr, ADDR_BAY0_STS) && i_reg_addr[1:0] == 2'h1;
		ff_wr[1] = i_reg_wr && hit(i_reg_addr, ADDR_BAY1_STS) && i_reg_addr[1:0] == 2'h1;
	end

	// next-state logic for both bays
	always_comb begin
		logic [2:0] wreq;
		logic new_lock;
		logic [31:0] word;
		st_nxt = st_r;
		wreq = REQ_NONE;
		new_lock = 1'b0;
		word = 32'h0;
		pls_start = 2'h0;
		st_nxt.syn1 = {i_security_lock_in_n, i_remove_request_in_n,
			i_usb_presence_in_n, i_serial_bus_presence_in_n};
		st_nxt.syn2 = st_r.syn1;
		// 50 ms timebase shared by both solenoid timers
		st_nxt.tick = (st_r.tick_cnt == TICK_CYCLES - 1);
		st_nxt.tick_cnt = st_nxt.tick ? 32'h0 : st_r.tick_cnt + 32'h1;
		st_nxt.rr_d = st_r.syn2[5:4];
		for (int b = 0; b < 2; b++) begin
			st_nxt.prs_d[b] = present[b];
			// software write to control byte 0
			if (ctl_wr[b]) begin
				wreq = i_reg_wdata[CTL_REQ_LSB +: 3];
				new_lock = i_reg_wdata[CTL_LOCK_BIT];
				// only a 1-to-0 change fires; 0-on-0 and 0-to-1 leave the output alone
				pls_start[b] = st_r.lock[b] & ~new_lock & ~level_mode;
				st_nxt.lock[b] = new_lock;
				st_nxt.rr_en[b] = i_reg_wdata[CTL_RR_EN_BIT];
				st_nxt.sc_en[b] = i_reg_wdata[CTL_SC_EN_BIT];
				st_nxt.wk_en[b] = i_reg_wdata[CTL_WAKE_EN_BIT];
				// lock and power may be set together; the new lock value counts
				st_nxt.pwr[b] = i_reg_wdata[CTL_PWR_BIT] & present[b] & new_lock;
				if (wreq != REQ_NONE) begin
					st_nxt.req[b] = wreq;
					if (present[b] && wreq <= 3'(ST_REM_ALLOWED)) begin
						st_nxt.bst[b] = wreq;
					end
				end
			end
			// sticky flags: write one clears, a same-cycle event still sets
			if (sts_wr[b]) begin
				st_nxt.rr_flag[b] = st_r.rr_flag[b] & ~i_reg_wdata[STS_RR_BIT];
				st_nxt.sc_flag[b] = st_r.sc_flag[b] & ~i_reg_wdata[STS_SC_BIT];
			end
			if (st_r.rr_d[b] && !st_r.syn2[4 + b]) begin
				st_nxt.rr_flag[b] = 1'b1;
			end
			if (insert_ev[b] ||
				(remove_ev[b] && !(st_r.bst[b] == 3'(ST_REM_ALLOWED) && !st_r.wk_en[b]))) begin
				st_nxt.sc_flag[b] = 1'b1;
			end
			// remove-request event: flag and enable both up, edge of either
			rr_ev[b] = st_nxt.rr_flag[b] & st_nxt.rr_en[b] &
				~(st_r.rr_flag[b] & st_r.rr_en[b]);
			if (remove_ev[b]) begin
				st_nxt.bst[b] = 3'(ST_EMPTY);
				st_nxt.req[b] = REQ_NONE;
				st_nxt.pwr[b] = 1'b0;
			end else if (insert_ev[b] && st_nxt.sc_en[b]) begin
				st_nxt.bst[b] = 3'(ST_INSERTED);
			end else if (rr_ev[b] && present[b]) begin
				st_nxt.bst[b] = 3'(ST_REM_REQUESTED);
			end
			// level mode follows the lock bit, pulsed mode follows the timer
			// one register stage on the pin in both modes, so no glitch on a mode change
			st_nxt.sol[b] = level_mode ? st_nxt.lock[b] : pls_act[b];
		end
		// registered read of one byte
		if (i_reg_rd) begin
			if (hit(i_reg_addr, ADDR_BAY0_CTL)) begin
				word = ctl_word(st_r, 0);
			end else if (hit(i_reg_addr, ADDR_BAY1_CTL)) begin
				word = ctl_word(st_r, 1);
			end else if (hit(i_reg_addr, ADDR_BAY0_STS)) begin
				word = sts_word(st_r, ff_r[0], i_security_lock_present, 0);
			end else if (hit(i_reg_addr, ADDR_BAY1_STS)) begin
				word = sts_word(st_r, ff_r[1], i_security_lock_present, 1);
			end else begin
				word = 32'h0;
			end
			st_nxt.rdata = word[8 * i_reg_addr[1:0] +: 8];
		end
	end

	always_ff @(posedge i_core_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			st_r <= CTL_INIT;
		end else begin
			st_r <= st_nxt;
		end
	end

	// form factor: no reset on the value; only power-on re-arms the write
	always_ff @(posedge i_core_clk) begin
		for (int b = 0; b < 2; b++) begin
			if (ff_wr[b] && !ff_done_r[b]) begin
				ff_r[b] <= i_reg_wdata[2:0];
			end
		end
	end

	always_ff @(posedge i_core_clk or negedge i_por_n) begin
		if (!i_por_n) begin
			ff_done_r <= 2'h0;
		end else begin
			ff_done_r <= ff_done_r | ff_wr;
		end
	end

	// per-bay pulse timers
	for (genvar g = 0; g < 2; g++) begin : g_sol
		solenoid_pulse u_pulse (
			.i_core_clk(i_core_clk),
			.i_rst_n(i_rst_n),
			.i_tick(st_r.tick),
			.i_start(pls_start[g]),
			.i_len(i_solenoid_length_field),
			.i_long(i_pulse_length_select),
			.o_active(pls_act[g])
		);
	end

	// outputs; alert is a level while an enabled flag stands
	assign o_reg_rdata = st_r.rdata;
	assign o_solenoid_drive_out = st_r.sol;
	assign o_rail_gate_drive_out = st_r.pwr;
	assign o_alert_out = |((st_r.sc_flag & st_r.sc_en) | (st_r.rr_flag & st_r.rr_en));

	ctl_reserved_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
		(i_reg_rd && i_reg_addr[7:2] == ADDR_BAY0_CTL[7:2] && i_reg_addr[1:0] != 2'h0)
		|=> o_reg_rdata == 8'h00)
		else $error("control reserved byte not zero");
	level_follow_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
		(level_mode && $past(level_mode)) |-> o_solenoid_drive_out == st_r.lock)
		else $error("level mode solenoid not following lock");
	power_refuse_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
		$rose(st_r.pwr[0]) |-> st_r.lock[0] && st_r.prs_d[0])
		else $error("power set without lock or device");
	removal_empty_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
		remove_ev[1] |=> st_r.bst[1] == 3'(ST_EMPTY) && st_r.req[1] == REQ_NONE
		&& !o_rail_gate_drive_out[1])
		else $error("removal did not empty bay");
	insert_flag_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
		insert_ev[0] |=> st_r.sc_flag[0] ##1 st_r.sc_flag[0] || $past(sts_wr[0]))
		else $error("insertion did not set status flag");
	rr_gate_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
		(!st_r.rr_en[0] && !ctl_wr[0]) |=> st_r.bst[0] != 3'(ST_REM_REQUESTED)
		|| $past(st_r.bst[0]) == 3'(ST_REM_REQUESTED))
		else $error("remove request moved bay while disabled");
	sec_zero_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
		(i_reg_rd && !i_security_lock_present && i_reg_addr == ADDR_BAY0_STS)
		|=> !o_reg_rdata[STS_SEC_BIT])
		else $error("security status read set without capability");
	ff_frozen_a: assert property (@(posedge i_core_clk) disable iff (!i_por_n)
		ff_done_r[0] |=> $stable(ff_r[0]))
		else $error("form factor changed after first write");
	wake_gate_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
		(remove_ev[1] && st_r.bst[1] == 3'(ST_REM_ALLOWED) && !st_r.wk_en[1]
		&& !st_r.sc_flag[1]) |=> !st_r.sc_flag[1])
		else $error("removal set flag with wake disabled");
	// interlock, request and reserved-byte checks
	rr_late_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
		(ctl_wr[0] && i_reg_wdata[CTL_RR_EN_BIT] && !st_r.rr_en[0] && st_r.rr_flag[0]
		&& present[0] && !insert_ev[0] && !remove_ev[0])
		|=> st_r.bst[0] == 3'(ST_REM_REQUESTED))
		else $error("late remove-request enable did not move bay");
	power_drop_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
		(remove_ev[0] && st_r.pwr[0]) |=> !st_r.pwr[0] && !o_rail_gate_drive_out[0])
		else $error("removal left rail power on");
	empty_req_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
		(ctl_wr[1] && !present[1] && !remove_ev[1]) |=> $stable(st_r.bst[1]))
		else $error("requested state applied in empty bay");
	sts_reserved_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
		(i_reg_rd && i_reg_addr[7:2] == ADDR_BAY0_STS[7:2] && i_reg_addr[1])
		|=> o_reg_rdata == 8'h00)
		else $error("status reserved byte not zero");
	// the timer lags the write by one cycle and the pin by one more
	pulse_quiet_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
		(ctl_wr[1] && !st_r.lock[1] && !level_mode && !pls_act[1])
		|-> ##2 !o_solenoid_drive_out[1])
		else $error("solenoid pulsed on write to a clear lock");

	// main scenarios the bench is expected to reach
	insert_cover_c: cover property (@(posedge i_core_clk) disable iff (!i_rst_n)
		insert_ev[0] && st_r.sc_en[0]);
	rr_cover_c: cover property (@(posedge i_core_clk) disable iff (!i_rst_n) rr_ev[0]);
	pulse_cover_c: cover property (@(posedge i_core_clk) disable iff (!i_rst_n)
		pls_start[1] ##2 o_solenoid_drive_out[1]);
	allowed_cover_c: cover property (@(posedge i_core_clk) disable iff (!i_rst_n)
		remove_ev[1] && st_r.bst[1] == 3'(ST_REM_ALLOWED));
endmodule
`default_nettype wire

// ### design/bay_regs_pkg.sv
// shared constants and types for the two-bay control and status registers
`default_nettype none
package bay_regs_pkg;
	// byte addresses of the per-bay registers
	localparam logic [7:0] ADDR_BAY0_CTL = 8'h10;
	localparam logic [7:0] ADDR_BAY0_STS = 8'h14;
	localparam logic [7:0] ADDR_BAY1_CTL = 8'h18;
	localparam logic [7:0] ADDR_BAY1_STS = 8'h20;
	// control register field positions
	localparam int CTL_LOCK_BIT = 7;
	localparam int CTL_REQ_LSB = 4;
	localparam int CTL_RR_EN_BIT = 3;
	localparam int CTL_SC_EN_BIT = 2;
	localparam int CTL_WAKE_EN_BIT = 1;
	localparam int CTL_PWR_BIT = 0;
	// status register field positions
	localparam int STS_FF_LSB = 8;
	localparam int STS_SEC_BIT = 7;
	localparam int STS_ST_LSB = 4;
	localparam int STS_RR_BIT = 3;
	localparam int STS_SC_BIT = 2;
	localparam int STS_SER_BIT = 1;
	localparam int STS_USB_BIT = 0;
	// reset values
	localparam logic [31:0] CTL_RESET = 32'h0000_0000;
	localparam logic [31:0] STS_RESET = 32'h0000_0000;
	// requested state: no change
	localparam logic [2:0] REQ_NONE = 3'h0;
	// solenoid timing: short unit and long unit, core clock in kHz
	localparam int SOL_SHORT_MS = 50;
	localparam int SOL_LONG_MS = 800;
	localparam int CLK_KHZ = 250000;
	localparam int SOL_TICK_CYC = SOL_SHORT_MS * CLK_KHZ;
	localparam logic [4:0] SOL_LONG_RATIO = 5'(SOL_LONG_MS / SOL_SHORT_MS);
	// bay states, encoded in order 0..4 as reported
	typedef enum logic [2:0] {
		ST_EMPTY,
		ST_INSERTED,
		ST_ENABLED,
		ST_REM_REQUESTED,
		ST_REM_ALLOWED
	} bay_state_t;
endpackage
`default_nettype wire

// ### design/solenoid_pulse.sv
// one-bay solenoid pulse timer counting 50 ms ticks
`default_nettype none
module solenoid_pulse
	import bay_regs_pkg::*;
(
	// clock and reset
	input wire logic i_core_clk,
	input wire logic i_rst_n,
	// timebase and trigger
	input wire logic i_tick,
	input wire logic i_start,
	input wire logic [3:0] i_len,
	input wire logic i_long,
	// pulse output
	output logic o_active
);
	typedef struct packed {
		logic act;
		logic [7:0] cnt;
	} pulse_t;
	pulse_t st_r;
	pulse_t st_nxt;

	// load tick count on start, count down on each tick
	always_comb begin
		st_nxt = st_r;
		if (i_start) begin
			// operands widened first so the product keeps all eight bits
			st_nxt.cnt = i_long ? {4'h0, i_len} * {3'h0, SOL_LONG_RATIO} : {4'h0, i_len};
			st_nxt.act = (i_len != 4'h0);
		end else if (i_tick && st_r.cnt != 8'h0) begin
			st_nxt.cnt = st_r.cnt - 8'h1;
			st_nxt.act = (st_r.cnt != 8'h1);
		end
	end

	always_ff @(posedge i_core_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			st_r <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign o_active = st_r.act;

	pulse_start_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
		(i_start && i_len != 4'h0) |=> o_active)
		else $error("solenoid pulse did not start");
	pulse_cover_c: cover property (@(posedge i_core_clk) disable iff (!i_rst_n)
		$fell(o_active));
endmodule
`default_nettype wire

// ### dv/bay_pins_model.sv
// bay connector side: presence contacts, remove button, security lock
`default_nettype none
module bay_pins_model (
	// contact states from the bench, one bit per bay
	input wire logic [1:0] i_usb_in,
	input wire logic [1:0] i_ser_in,
	input wire logic [1:0] i_press,
	input wire logic [1:0] i_locked,
	// active-low pins, pulled up when the contact is open
	output logic [1:0] o_usb_n,
	output logic [1:0] o_ser_n,
	output logic [1:0] o_rem_n,
	output logic [1:0] o_sec_n
);
	timeunit 1ns;
	timeprecision 1ps;
	// an open contact floats to the pull-up, a closed one grounds the pin
	assign o_usb_n = ~i_usb_in;
	assign o_ser_n = ~i_ser_in;
	assign o_rem_n = ~i_press;
	assign o_sec_n = ~i_locked;
endmodule
`default_nettype wire

// ### dv/device_bay_control_status_regs_test.sv
// self-checking bench for the two-bay register bank
`default_nettype none
`define CHK(n, e, g) begin total_checks++; if ((g) !== (e)) begin n_mismatch++; \
	$display("[ERR] %s exp %h got %h", n, e, g); end end
module device_bay_control_status_regs_test;
	import bay_regs_pkg::*;
	timeunit 1ns;
	timeprecision 1ps;
	// short tick keeps solenoid pulses to a few hundred cycles
	localparam int T = 10;
	logic clk = 0, rst_n = 0, por_n = 0, wr = 0, rd = 0, lsel = 0, secp = 0;
	logic [7:0] addr = 8'h00, wdata = 8'h00, rdata, v;
	logic [3:0] len = 4'h0;
	logic [2:0] ff;
	logic [1:0] usb = 2'h0, ser = 2'h0, prs = 2'h0, lck = 2'h0;
	logic [1:0] usb_n, ser_n, rem_n, sec_n, sol, rail;
	logic alert;
	int n_mismatch = 0, total_checks = 0, seed = 71879, cnt, pm;
	always #2 clk = ~clk;
	bay_pins_model u_bay_pins_model (.i_usb_in(usb), .i_ser_in(ser), .i_press(prs),
		.i_locked(lck), .o_usb_n(usb_n), .o_ser_n(ser_n), .o_rem_n(rem_n), .o_sec_n(sec_n));
	bay_ctl_regs #(.TICK_CYCLES(T)) u_bay_ctl_regs (.i_core_clk(clk), .i_rst_n(rst_n),
		.i_por_n(por_n), .i_reg_addr(addr), .i_reg_wr(wr), .i_reg_wdata(wdata),
		.i_reg_rd(rd), .o_reg_rdata(rdata), .i_solenoid_length_field(len),
		.i_pulse_length_select(lsel), .i_security_lock_present(secp),
		.i_serial_bus_presence_in_n(ser_n), .i_usb_presence_in_n(usb_n),
		.i_remove_request_in_n(rem_n), .i_security_lock_in_n(sec_n),
		.o_solenoid_drive_out(sol), .o_rail_gate_drive_out(rail), .o_alert_out(alert));
	// expected status byte from its fields
	function automatic logic [7:0] sb(logic s, logic [2:0] st, logic r, logic c, logic p1,
		logic p0);
		return {s, st, r, c, p1, p0};
	endfunction
	// longest legal pulse in cycles; long units are sixteen short ones
	function automatic int pmax(logic [3:0] l, logic g);
		return int'(l) * (g ? 16 : 1) * T;
	endfunction
	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	task automatic wr_b(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		#1;
		addr = a;
		wdata = d;
		wr = 1;
		@(posedge clk);
		#1;
		wr = 0;
	endtask
	// read data is registered, so it is taken one cycle after the strobe
	task automatic rchk(input logic [7:0] a, input logic [7:0] e, input string n);
		@(posedge clk);
		#1;
		addr = a;
		rd = 1;
		@(posedge clk);
		#1;
		rd = 0;
		v = rdata;
		`CHK(n, e, v)
	endtask
	task print_verdict;
		$display("checks %0d mismatches %0d", total_checks, n_mismatch);
		if (n_mismatch == 0 && total_checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	// watchdog sized well above the whole sequence
	initial begin
		#160000;
		n_mismatch++;
		print_verdict;
	end
	initial begin
		logic [7:0] ra[4];
		ra = '{ADDR_BAY0_CTL, ADDR_BAY0_STS, ADDR_BAY1_CTL, ADDR_BAY1_STS};
		ff = 3'(($random(seed) & 32'hffff) % 3);
		cyc(12);
		rst_n = 1;
		por_n = 1;
		foreach (ra[i]) rchk(ra[i], 8'h00, "reset value");
		rchk(8'h11, 8'h00, "ctl byte1");
		rchk(8'h17, 8'h00, "sts byte3");
		rchk(8'h30, 8'h00, "unmapped");
		// form factor takes only the first write
		wr_b(8'h15, {5'h0, ff});
		wr_b(8'h15, {5'h0, ff ^ 3'h1});
		rchk(8'h15, {5'h0, ff}, "form factor");
		// power refused in an empty bay, lock still taken
		wr_b(ADDR_BAY0_CTL, 8'h85);
		rchk(ADDR_BAY0_CTL, 8'h84, "pwr refused");
		`CHK("rail empty", 2'h0, rail)
		`CHK("sol level", 2'h1, sol)
		usb[0] = 1;
		cyc(6);
		rchk(ADDR_BAY0_STS, sb(0, 3'h1, 0, 1, 0, 1), "insert");
		`CHK("alert ins", 1'b1, alert)
		wr_b(ADDR_BAY0_STS, 8'h04);
		rchk(ADDR_BAY0_STS, sb(0, 3'h1, 0, 0, 0, 1), "sc clear");
		`CHK("alert clr", 1'b0, alert)
		wr_b(ADDR_BAY0_CTL, 8'ha5);
		rchk(ADDR_BAY0_STS, sb(0, 3'h2, 0, 0, 0, 1), "enabled");
		`CHK("rail on", 2'h1, rail)
		wr_b(ADDR_BAY0_CTL, 8'h85);
		rchk(ADDR_BAY0_CTL, 8'ha5, "req kept");
		// button press while its enable is off
		prs[0] = 1;
		cyc(6);
		prs[0] = 0;
		cyc(2);
		rchk(ADDR_BAY0_STS, sb(0, 3'h2, 1, 0, 0, 1), "rr off");
		`CHK("alert rr off", 1'b0, alert)
		wr_b(ADDR_BAY0_CTL, 8'h8d);
		cyc(2);
		rchk(ADDR_BAY0_STS, sb(0, 3'h3, 1, 0, 0, 1), "rr late en");
		`CHK("alert rr", 1'b1, alert)
		wr_b(ADDR_BAY0_STS, 8'h08);
		rchk(ADDR_BAY0_STS, sb(0, 3'h3, 0, 0, 0, 1), "rr clear");
		// sudden removal with power on
		usb[0] = 0;
		cyc(6);
		rchk(ADDR_BAY0_STS, sb(0, 3'h0, 0, 1, 0, 0), "removed");
		rchk(ADDR_BAY0_CTL, 8'h8c, "req pwr clr");
		`CHK("rail off", 2'h0, rail)
		secp = 1;
		lck[0] = 1;
		cyc(6);
		rchk(ADDR_BAY0_STS, sb(1, 3'h0, 0, 1, 0, 0), "sec lock");
		secp = 0;
		rchk(ADDR_BAY0_STS, sb(0, 3'h0, 0, 1, 0, 0), "sec no cap");
		wr_b(ADDR_BAY0_STS, 8'h04);
		// bay 1: request with no device, then removal while allowed, wake off
		wr_b(ADDR_BAY1_CTL, 8'h20);
		rchk(ADDR_BAY1_STS, 8'h00, "no device");
		ser[1] = 1;
		cyc(6);
		rchk(ADDR_BAY1_STS, sb(0, 3'h0, 0, 1, 1, 0), "b1 insert");
		`CHK("alert sc off", 1'b0, alert)
		wr_b(ADDR_BAY1_STS, 8'h04);
		wr_b(ADDR_BAY1_CTL, 8'h40);
		rchk(ADDR_BAY1_STS, sb(0, 3'h4, 0, 0, 1, 0), "allowed");
		ser[1] = 0;
		cyc(6);
		rchk(ADDR_BAY1_STS, 8'h00, "wake off");
		wr_b(ADDR_BAY1_CTL, 8'h80);
		cyc(1);
		`CHK("sol1 set", 2'h2, sol & 2'h2)
		wr_b(ADDR_BAY1_CTL, 8'h00);
		cyc(1);
		`CHK("sol1 clr", 2'h0, sol & 2'h2)
		// pulsed mode: random short length, then two long units
		for (int k = 0; k < 2; k++) begin
			len = k ? 4'h2 : 4'(1 + ($random(seed) & 32'hff) % 3);
			lsel = k[0];
			pm = pmax(len, lsel);
			wr_b(ADDR_BAY1_CTL, 8'h80);
			cyc(3);
			`CHK("no pulse set", 1'b0, sol[1])
			wr_b(ADDR_BAY1_CTL, 8'h00);
			cnt = 0;
			repeat (pm + 2 * T + 4) begin
				@(posedge clk);
				#1;
				if (sol[1] === 1'b1)
					cnt++;
			end
			`CHK("pulse width", 1'b1, cnt > pm - T && cnt <= pm)
			wr_b(ADDR_BAY1_CTL, 8'h00);
			cyc(3);
			`CHK("no pulse 0", 1'b0, sol[1])
		end
		// a reset in mid-run leaves the form factor alone
		rst_n = 0;
		cyc(2);
		rst_n = 1;
		rchk(8'h15, {5'h0, ff}, "ff after rst");
		rchk(ADDR_BAY0_CTL, 8'h00, "ctl after rst");
		print_verdict;
	end
endmodule
`default_nettype wire
